// File: design/bats_acceptor.sv
// acceptor side of the three-wire handshake: takes one byte per DAV pulse
// assumes davIn, dioIn, eoiIn and atnIn are synchronous, logical levels

`timescale 1ns/10ps
`default_nettype none

module bats_acceptor
  import bats_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       active,
  input  wire logic       ready,
  input  wire logic       davIn,
  input  wire logic [7:0] dioIn,
  input  wire logic       eoiIn,
  input  wire logic       atnIn,
  output logic            nrfdAssert,
  output logic            ndacAssert,
  output logic            byteStrobe,
  output logic [7:0]      byteData,
  output logic            byteEoi,
  output logic            byteAtn
);

  typedef struct packed {
    bats_acc_e  state;
    logic [7:0] data;
    logic       eoi;
    logic       atn;
  } bats_acc_s;

  bats_acc_s cur;
  bats_acc_s next_cur;

  always_comb
  begin
    next_cur = cur;
    unique case (cur.state)
      ACC_READY:
      begin
        if (active && ready && davIn)
        begin
          next_cur.state = ACC_TAKE;
          next_cur.data  = dioIn;
          next_cur.eoi   = eoiIn;
          next_cur.atn   = atnIn;
        end
      end
      ACC_TAKE:
        next_cur.state = active ? ACC_WAIT : ACC_READY;
      ACC_WAIT:
      begin
        if (!davIn || !active)
          next_cur.state = ACC_READY;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      cur <= '{state: ACC_READY, data: BYTE_RESET, eoi: 1'b0, atn: 1'b0};
    else
      cur <= next_cur;
  end

  // not ready first, then accepted; NDAC returns once DAV drops
  assign nrfdAssert = active && (cur.state != ACC_READY || !ready);
  assign ndacAssert = active && (cur.state != ACC_WAIT);
  assign byteStrobe = (cur.state == ACC_TAKE);
  assign byteData   = cur.data;
  assign byteEoi    = cur.eoi;
  assign byteAtn    = cur.atn;

endmodule : bats_acceptor

`default_nettype wire

// File: design/bats_pkg.sv
// constants, state types and timing counts for the bus address, termination and serial poll block
// assumes a single 100 MHz clock domain and logical (asserted = 1) bus levels at every port

package bats_pkg;

  localparam logic [7:0] LISTEN_BASE      = 8'h20;
  localparam logic [7:0] TALK_BASE        = 8'h40;
  localparam logic [7:0] SECOND_BASE      = 8'h60;
  localparam logic [7:0] UNLISTEN_CMD     = 8'h3f;
  localparam logic [7:0] UNTALK_CMD       = 8'h5f;
  localparam logic [7:0] POLL_ENABLE_CMD  = 8'h18;
  localparam logic [7:0] POLL_DISABLE_CMD = 8'h19;
  localparam logic [1:0] GROUP_LISTEN     = 2'h1;
  localparam logic [1:0] GROUP_TALK       = 2'h2;
  localparam logic [1:0] GROUP_SECOND     = 2'h3;
  localparam logic [4:0] ADDR_MAX         = 5'h1e;
  localparam logic [4:0] ADDR_NONE        = 5'h1f;
  localparam int         RQS_BIT          = 6;
  localparam int         COUNT_W          = 16;
  localparam logic [7:0] BYTE_RESET       = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE   = 16'h0001;

  localparam int CLK_PERIOD_NS = 10;
  localparam int DATA_SETTLE_NS = 30;
  localparam int SETTLE_RAW = (DATA_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
  localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_CYCLES - 1);
  localparam logic [3:0] SETTLE_RESET = 4'h0;

  typedef enum logic [1:0] {ACC_READY, ACC_TAKE, ACC_WAIT} bats_acc_e;
  typedef enum logic [1:0] {SRC_IDLE, SRC_SETTLE, SRC_WAITRDY, SRC_DAV} bats_src_e;

endpackage : bats_pkg

// File: design/bats_port.sv
// device-side command decoder, addressing state, termination and serial poll
// assumes bus lines arrive synchronous as logical levels; an outside driver turns oe into open-collector

`timescale 1ns/10ps
`default_nettype none

module bats_port
  import bats_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire logic               atnIn,
  input  wire logic [7:0]         dioIn,
  output logic [7:0]              dioOut,
  output logic                    dioOe,
  input  wire logic               davIn,
  output logic                    davOut,
  output logic                    davOe,
  input  wire logic               nrfdIn,
  output logic                    nrfdOut,
  output logic                    nrfdOe,
  input  wire logic               ndacIn,
  output logic                    ndacOut,
  output logic                    ndacOe,
  input  wire logic               eoiIn,
  output logic                    eoiOut,
  output logic                    eoiOe,
  input  wire logic               srqIn,
  output logic                    srqOut,
  output logic                    srqOe,
  input  wire logic [4:0]         myAddr,
  input  wire logic               secEnable,
  input  wire logic [4:0]         mySecAddr,
  input  wire logic               eosEnable,
  input  wire logic               eoiEnable,
  input  wire logic               countEnable,
  input  wire logic [7:0]         eosChar,
  input  wire logic [COUNT_W-1:0] countLimit,
  input  wire logic               userReady,
  input  wire logic               readRestart,
  output logic                    rxValid,
  output logic [7:0]              rxData,
  output logic                    rxEnd,
  output logic                    endByEos,
  output logic                    endByEoi,
  output logic                    endByCount,
  output logic                    holdActive,
  input  wire logic               txValid,
  input  wire logic [7:0]         txData,
  input  wire logic               txLast,
  output logic                    txReady,
  output logic                    txDone,
  input  wire logic [7:0]         statusBits,
  input  wire logic               srqRequest,
  output logic                    listenActive,
  output logic                    talkActive,
  output logic                    pollMode,
  output logic                    srqActive
);

  typedef struct packed {
    logic               listen;
    logic               talk;
    logic               lpas;
    logic               tpas;
    logic               spMode;
    logic               spSent;
    logic               srq;
    logic               hold;
    logic [COUNT_W-1:0] count;
    logic               rxValid;
    logic [7:0]         rxData;
    logic               rxEnd;
    logic               endEos;
    logic               endEoi;
    logic               endCount;
    bats_src_e          src;
    logic [3:0]         settle;
    logic [7:0]         txByte;
    logic               txEoi;
    logic               txIsPoll;
  } bats_port_s;

  bats_port_s cur;
  bats_port_s next_cur;

  logic               accStb;
  logic [7:0]         accData;
  logic               accEoi;
  logic               accAtn;
  logic               accActive;
  logic               accReady;
  logic               isCmd;
  logic               isData;
  logic [7:0]         cmdByte;
  logic [1:0]         cmdGroup;
  logic [4:0]         cmdAddr;
  logic               addrValid;
  logic               ownAddr;
  logic [COUNT_W-1:0] cntNext;
  logic               eosHit;
  logic               eoiHit;
  logic               cntHit;
  logic               spLoad;
  logic               pollDone;
  logic               byteDone;

  // commands always handshaken; data only while listening and not held
  assign accActive = atnIn || cur.listen;
  assign accReady  = atnIn || (cur.listen && !cur.hold && userReady);

  bats_acceptor u_acceptor (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .active     (accActive),
    .ready      (accReady),
    .davIn      (davIn),
    .dioIn      (dioIn),
    .eoiIn      (eoiIn),
    .atnIn      (atnIn),
    .nrfdAssert (nrfdOe),
    .ndacAssert (ndacOe),
    .byteStrobe (accStb),
    .byteData   (accData),
    .byteEoi    (accEoi),
    .byteAtn    (accAtn)
  );

  assign isCmd     = accStb && accAtn;
  assign isData    = accStb && !accAtn && cur.listen;
  assign cmdByte   = {1'b0, accData[6:0]};
  assign cmdGroup  = accData[6:5];
  assign cmdAddr   = accData[4:0];
  assign addrValid = (myAddr <= ADDR_MAX);
  assign ownAddr   = addrValid && (cmdAddr == myAddr);

  // termination tests see data bytes only
  assign cntNext = cur.count + COUNT_ONE;
  assign eosHit  = isData && eosEnable && (accData == eosChar);
  assign eoiHit  = isData && eoiEnable && accEoi;
  assign cntHit  = isData && countEnable && (cntNext >= countLimit);

  assign spLoad   = (cur.src == SRC_IDLE) && cur.talk && cur.spMode && !cur.spSent && !atnIn;
  assign txReady  = (cur.src == SRC_IDLE) && cur.talk && !cur.spMode && !atnIn;
  assign byteDone = (cur.src == SRC_DAV) && !ndacIn && !atnIn && cur.talk;
  assign pollDone = byteDone && cur.txIsPoll;

  always_comb
  begin
    next_cur          = cur;
    next_cur.rxValid  = 1'b0;
    next_cur.rxEnd    = 1'b0;
    next_cur.endEos   = 1'b0;
    next_cur.endEoi   = 1'b0;
    next_cur.endCount = 1'b0;

    if (isCmd)
    begin
      // a pending primary match lives for the very next command only
      next_cur.lpas = 1'b0;
      next_cur.tpas = 1'b0;
      if (cmdByte == UNLISTEN_CMD)
        next_cur.listen = 1'b0;
      else if (cmdByte == UNTALK_CMD)
        next_cur.talk = 1'b0;
      else if (cmdByte == POLL_ENABLE_CMD)
      begin
        next_cur.spMode = 1'b1;
        next_cur.spSent = 1'b0;
      end
      else if (cmdByte == POLL_DISABLE_CMD)
        next_cur.spMode = 1'b0;
      else if (cmdGroup == GROUP_LISTEN)
      begin
        if (ownAddr && secEnable)
          next_cur.lpas = 1'b1;
        else if (ownAddr)
          next_cur.listen = 1'b1;
      end
      else if (cmdGroup == GROUP_TALK)
      begin
        if (ownAddr && secEnable)
          next_cur.tpas = 1'b1;
        else if (ownAddr)
          next_cur.talk = 1'b1;
        else
          next_cur.talk = 1'b0;
      end
      else if (cmdGroup == GROUP_SECOND && cmdAddr != ADDR_NONE)
      begin
        if (cur.lpas && cmdAddr == mySecAddr)
          next_cur.listen = 1'b1;
        if (cur.tpas && cmdAddr == mySecAddr)
          next_cur.talk = 1'b1;
      end
    end

    if (readRestart)
    begin
      next_cur.hold  = 1'b0;
      next_cur.count = COUNT_RESET;
    end

    if (isData)
    begin
      next_cur.rxValid  = 1'b1;
      next_cur.rxData   = accData;
      next_cur.endEos   = eosHit;
      next_cur.endEoi   = eoiHit;
      next_cur.endCount = cntHit;
      next_cur.rxEnd    = eosHit || eoiHit || cntHit;
      next_cur.count    = (eosHit || eoiHit || cntHit) ? COUNT_RESET : cntNext;
      if (cntHit)
        next_cur.hold = 1'b1;
    end

    unique case (cur.src)
      SRC_IDLE:
      begin
        if (spLoad)
        begin
          next_cur.txByte   = {statusBits[7], cur.srq, statusBits[5:0]};
          next_cur.txEoi    = 1'b0;
          next_cur.txIsPoll = 1'b1;
          next_cur.spSent   = 1'b1;
          next_cur.src      = SRC_SETTLE;
          next_cur.settle   = SETTLE_RESET;
        end
        else if (txValid && txReady)
        begin
          next_cur.txByte   = txData;
          // end character goes out with end line when both are in use
          next_cur.txEoi    = txLast || (eoiEnable && eosEnable && txData == eosChar);
          next_cur.txIsPoll = 1'b0;
          next_cur.src      = SRC_SETTLE;
          next_cur.settle   = SETTLE_RESET;
        end
      end
      SRC_SETTLE:
      begin
        if (!atnIn)
        begin
          if (cur.settle == SETTLE_LAST)
            next_cur.src = SRC_WAITRDY;
          else
            next_cur.settle = cur.settle + 4'h1;
        end
      end
      SRC_WAITRDY:
      begin
        if (!nrfdIn)
          next_cur.src = SRC_DAV;
      end
      SRC_DAV:
      begin
        if (!ndacIn)
          next_cur.src = SRC_IDLE;
      end
    endcase

    // ATN seizes the bus: step back and resettle the same byte
    if (atnIn && (cur.src == SRC_WAITRDY || cur.src == SRC_DAV))
    begin
      next_cur.src    = SRC_SETTLE;
      next_cur.settle = SETTLE_RESET;
    end
    if (!cur.talk)
      next_cur.src = SRC_IDLE;

    if (pollDone)
      next_cur.srq = 1'b0;
    if (srqRequest)
      next_cur.srq = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      cur <= '{listen: 1'b0, talk: 1'b0, lpas: 1'b0, tpas: 1'b0, spMode: 1'b0, spSent: 1'b0,
               srq: 1'b0, hold: 1'b0, count: COUNT_RESET, rxValid: 1'b0, rxData: BYTE_RESET,
               rxEnd: 1'b0, endEos: 1'b0, endEoi: 1'b0, endCount: 1'b0, src: SRC_IDLE,
               settle: SETTLE_RESET, txByte: BYTE_RESET, txEoi: 1'b0, txIsPoll: 1'b0};
    else
      cur <= next_cur;
  end

  assign dioOut       = cur.txByte;
  assign dioOe        = (cur.src != SRC_IDLE) && !atnIn;
  assign davOut       = davOe;
  assign davOe        = (cur.src == SRC_DAV) && !atnIn;
  assign eoiOut       = eoiOe;
  assign eoiOe        = dioOe && cur.txEoi;
  assign nrfdOut      = nrfdOe;
  assign ndacOut      = ndacOe;
  // service request line needs no addressing
  assign srqOut       = srqOe;
  assign srqOe        = cur.srq;
  assign txDone       = byteDone;
  assign rxValid      = cur.rxValid;
  assign rxData       = cur.rxData;
  assign rxEnd        = cur.rxEnd;
  assign endByEos     = cur.endEos;
  assign endByEoi     = cur.endEoi;
  assign endByCount   = cur.endCount;
  assign holdActive   = cur.hold;
  assign listenActive = cur.listen;
  assign talkActive   = cur.talk;
  assign pollMode     = cur.spMode;
  assign srqActive    = cur.srq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_listen_address: assert property (isCmd && cmdGroup == GROUP_LISTEN && ownAddr && !secEnable
    && cmdByte != UNLISTEN_CMD |=> listenActive) else $error("own listen address not taken");
  a_talk_address: assert property (isCmd && cmdByte == (TALK_BASE | {3'h0, myAddr}) && addrValid
    && !secEnable |=> talkActive) else $error("own talk address not taken");
  a_second_address: assert property (isCmd && cmdGroup == GROUP_SECOND && cmdAddr == mySecAddr
    && cmdAddr != ADDR_NONE && cur.lpas
    |=> listenActive) else $error("primary plus secondary did not address listener");
  a_untalk_clears: assert property (isCmd && cmdByte == UNTALK_CMD |=> !talkActive)
    else $error("untalk left talker addressed");
  a_other_talker: assert property (isCmd && cmdGroup == GROUP_TALK && cmdAddr != myAddr
    |=> !talkActive) else $error("other talk address did not unaddress");
  a_unlisten_clears: assert property (isCmd && cmdByte == UNLISTEN_CMD |=> !listenActive)
    else $error("unlisten left listener addressed");
  a_end_data_only: assert property (rxEnd |-> $past(accStb && !accAtn))
    else $error("end of transfer from a command byte");
  a_eos_ends: assert property (isData && eosEnable && accData == eosChar
    |=> rxEnd && endByEos && rxData == $past(eosChar)) else $error("end character missed");
  a_eoi_ends: assert property (isData && eoiEnable && accEoi |=> rxEnd && endByEoi)
    else $error("end line byte not last");
  a_count_holds: assert property (endByCount && !readRestart |=> holdActive
    && (!listenActive || atnIn || nrfdOe)) else $error("count end did not hold off talker");
  a_end_any: assert property (rxValid && !rxEnd |-> !endByEos && !endByEoi && !endByCount)
    else $error("end cause without end");
  a_eos_with_eoi: assert property (davOe && eoiEnable && eosEnable && dioOut == eosChar
    && !cur.txIsPoll && $stable(eosChar) |-> eoiOe) else $error("end character sent without end line");
  a_poll_rqs: assert property ($rose(dioOe) && cur.txIsPoll
    |-> dioOut[RQS_BIT] == $past(srqActive)) else $error("status bit 6 wrong");
  a_poll_exit: assert property (isCmd && cmdByte == POLL_DISABLE_CMD |=> !pollMode)
    else $error("poll disable ignored");
  a_srq_release: assert property (pollDone && !srqRequest |=> !srqOe)
    else $error("service request not released");
  a_dav_after_ready: assert property ($rose(davOe) |-> $past(!nrfdIn) && dioOe)
    else $error("DAV raised while not ready");

  c_listen_addressed: cover property ($rose(listenActive));
  c_poll_read: cover property (pollDone);
  c_count_end: cover property (endByCount);
  c_talk_byte: cover property (byteDone && !cur.txIsPoll && eoiOe);

endmodule : bats_port

`default_nettype wire

// File: verification/bats_ctrl_model.sv
// bus controller and far-side listener model for the instrument port
// assumes open-collector lines with pull-ups: a released line reads unasserted (0)

`timescale 1ns/10ps
`default_nettype none

module bats_ctrl_model
(
  input  wire logic       sys_clk,
  input  wire logic       nrfdW,
  input  wire logic       ndacW,
  input  wire logic       davW,
  input  wire logic [7:0] dioW,
  input  wire logic       eoiW,
  output logic            atn,
  output logic [7:0]      dio,
  output logic            dav,
  output logic            eoi,
  output logic            nrfd,
  output logic            ndac
);
  initial {atn, dio, dav, eoi, nrfd, ndac} = '0;

  // one byte as controller or talker; ok low when held off
  task automatic send(input logic a, input logic [7:0] d, input logic e, output logic ok);
    int n;
    n = 0;
    @(negedge sys_clk);
    atn = a;
    dio = d;
    eoi = e;
    repeat (3) @(negedge sys_clk);
    while (nrfdW !== 1'b0 && n < 40)
    begin
      @(negedge sys_clk);
      n++;
    end
    ok = (n < 40);
    if (ok)
    begin
      dav = 1'b1;
      n = 0;
      do @(negedge sys_clk); while (ndacW !== 1'b0 && n++ < 40);
      @(negedge sys_clk);
    end
    dav = 1'b0;
    dio = 8'h00;
    eoi = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : send

  // one byte as listener while the device talks
  task automatic recv(output logic [7:0] d, output logic e);
    int n;
    n = 0;
    @(negedge sys_clk);
    atn = 1'b0;
    ndac = 1'b1;
    while (davW !== 1'b1 && n < 60)
    begin
      @(negedge sys_clk);
      n++;
    end
    d = dioW;
    e = eoiW;
    nrfd = 1'b1;
    ndac = 1'b0;
    n = 0;
    while (davW !== 1'b0 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    nrfd = 1'b0;
  endtask : recv
endmodule : bats_ctrl_model

`default_nettype wire

// File: verification/tb_bats_port.sv
// self-checking bench for bats_port against the controller model
// assumes one 100 MHz clock; inputs change on the falling edge

`timescale 1ns/10ps
`default_nettype none

module tb_bats_port
  import bats_pkg::*;
;
  logic sys_clk = 0, nrst = 0, srqRequest = 0, readRestart = 0, txValid = 0, txLast = 0;
  logic secEnable = 0, eosEnable = 0, eoiEnable = 0, countEnable = 0, userReady = 1, ok, ge;
  logic [4:0] myAddr = 5'h05, mySecAddr = 5'h03;
  logic [7:0] eosChar = 8'h0d, txData = 8'h00, statusBits = 8'h81, lastRx = 8'h00, gd;
  logic [3:0] lastFlags = 4'h0;
  logic [COUNT_W-1:0] countLimit = 16'hffff;
  logic [7:0] dioOut, ctlDio, rxData;
  logic cAtn, cDav, cEoi, cNrfd, cNdac, dioOe, davOut, davOe, nrfdOut, nrfdOe, ndacOut, ndacOe;
  logic eoiOut, eoiOe, srqOut, srqOe, rxValid, rxEnd, endByEos, endByEoi, endByCount, holdActive;
  logic txReady, txDone, listenActive, talkActive, pollMode, srqActive;
  wire logic [7:0] dioW = ctlDio | (dioOe ? dioOut : 8'h00);
  wire logic davW = cDav | (davOe & davOut);
  wire logic nrfdW = cNrfd | (nrfdOe & nrfdOut);
  wire logic ndacW = cNdac | (ndacOe & ndacOut);
  wire logic eoiW = cEoi | (eoiOe & eoiOut);
  int mismatches = 0, check_count = 0, rxCnt = 0, txCnt = 0, cycles = 0;

  always #5 sys_clk = ~sys_clk;

  bats_port dut (.sys_clk(sys_clk), .nrst(nrst), .atnIn(cAtn), .dioIn(dioW), .dioOut(dioOut),
    .dioOe(dioOe), .davIn(davW), .davOut(davOut), .davOe(davOe), .nrfdIn(nrfdW), .nrfdOut(nrfdOut),
    .nrfdOe(nrfdOe), .ndacIn(ndacW), .ndacOut(ndacOut), .ndacOe(ndacOe), .eoiIn(eoiW), .eoiOut(eoiOut),
    .eoiOe(eoiOe), .srqIn(1'b0), .srqOut(srqOut), .srqOe(srqOe), .myAddr(myAddr), .secEnable(secEnable),
    .mySecAddr(mySecAddr), .eosEnable(eosEnable), .eoiEnable(eoiEnable), .countEnable(countEnable),
    .eosChar(eosChar), .countLimit(countLimit), .userReady(userReady), .readRestart(readRestart),
    .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd), .endByEos(endByEos), .endByEoi(endByEoi),
    .endByCount(endByCount), .holdActive(holdActive), .txValid(txValid), .txData(txData),
    .txLast(txLast), .txReady(txReady), .txDone(txDone), .statusBits(statusBits),
    .srqRequest(srqRequest), .listenActive(listenActive), .talkActive(talkActive),
    .pollMode(pollMode), .srqActive(srqActive));

  bats_ctrl_model u_ctl (.sys_clk(sys_clk), .nrfdW(nrfdW), .ndacW(ndacW), .davW(davW), .dioW(dioW),
    .eoiW(eoiW), .atn(cAtn), .dio(ctlDio), .dav(cDav), .eoi(cEoi), .nrfd(cNrfd), .ndac(cNdac));

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (rxValid === 1'b1)
    begin
      lastRx <= rxData;
      lastFlags <= {rxEnd, endByEos, endByEoi, endByCount};
      rxCnt <= rxCnt + 1;
    end
    if (txDone === 1'b1)
      txCnt <= txCnt + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cmd(input logic [7:0] b);
    u_ctl.send(1'b1, b, 1'b0, ok);
  endtask : cmd

  task automatic data(input logic [7:0] b, input logic e);
    u_ctl.send(1'b0, b, e, ok);
  endtask : data

  // device talks one byte while the model listens
  task automatic talk_byte(input logic [7:0] d, input logic expE);
    int n;
    n = 0;
    fork
      begin
        // let the model drop atn first, so txReady is settled when looked at
        repeat (2) @(negedge sys_clk);
        txValid = 1'b1;
        txData = d;
        while (txReady !== 1'b1 && n < 60)
        begin
          @(negedge sys_clk);
          n++;
        end
        @(negedge sys_clk);
        txValid = 1'b0;
      end
      u_ctl.recv(gd, ge);
    join
    check({8'h00, gd}, {8'h00, d});
    check({15'h0, ge}, {15'h0, expE});
  endtask : talk_byte

  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : pulse

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    cmd(8'ha5);
    check({15'h0, listenActive}, 16'h0001);
    eosEnable = 1'b1;
    cmd(8'h0d);
    check(16'(rxCnt), 16'h0000);
    data(8'h41, 1'b0);
    data(8'h0d, 1'b0);
    check({8'h00, lastRx}, 16'h000d);
    check({12'h0, lastFlags}, 16'h000c);
    eoiEnable = 1'b1;
    eosChar = 8'h0a;
    data(8'h0a, 1'b1);
    check({12'h0, lastFlags}, 16'h000e);
    data(8'h42, 1'b1);
    check({12'h0, lastFlags}, 16'h000a);
    {eosEnable, eoiEnable, countEnable} = 3'b001;
    countLimit = 16'h0002;
    data(8'h01, 1'b0);
    data(8'h02, 1'b0);
    check({12'h0, lastFlags}, 16'h0009);
    check({15'h0, holdActive}, 16'h0001);
    data(8'h03, 1'b0);
    check({15'h0, ok}, 16'h0000);
    countEnable = 1'b0;
    pulse(readRestart);
    data(8'h03, 1'b0);
    check({15'h0, ok}, 16'h0001);
    check(16'(rxCnt), 16'h0007);
    cmd(8'h3f);
    check({15'h0, listenActive}, 16'h0000);
    cmd(8'h45);
    check({15'h0, talkActive}, 16'h0001);
    talk_byte(8'h55, 1'b0);
    {eosEnable, eoiEnable} = 2'b11;
    eosChar = 8'h0d;
    talk_byte(8'h0d, 1'b1);
    {eosEnable, eoiEnable} = 2'b00;
    txLast = 1'b1;
    talk_byte(8'h33, 1'b1);
    txLast = 1'b0;
    cmd(8'h46);
    check({15'h0, talkActive}, 16'h0000);
    cmd(8'h45);
    cmd(8'h5f);
    check({15'h0, talkActive}, 16'h0000);
    secEnable = 1'b1;
    cmd(8'h25);
    cmd(8'h63);
    check({15'h0, listenActive}, 16'h0001);
    cmd(8'h3f);
    cmd(8'h25);
    cmd(8'h64);
    check({15'h0, listenActive}, 16'h0000);
    secEnable = 1'b0;
    pulse(srqRequest);
    check({15'h0, srqOe}, 16'h0001);
    cmd(8'h18);
    check({15'h0, pollMode}, 16'h0001);
    cmd(8'h45);
    u_ctl.recv(gd, ge);
    check({8'h00, gd}, 16'h00c1);
    repeat (2) @(negedge sys_clk);
    check({15'h0, srqOe}, 16'h0000);
    check(16'(txCnt), 16'h0004);
    cmd(8'h19);
    check({15'h0, pollMode}, 16'h0000);
    give_verdict();
  end
endmodule : tb_bats_port

`default_nettype wire
